// *** rtl/iefc_pkg.sv ***
// Package for the interrupt enable and flag controller
package iefc_pkg;

  // Register byte addresses on APB
  localparam logic [11:0] IEFC_CTRL_OFFS = 12'h000;
  localparam logic [11:0] IEFC_PEN_OFFS = 12'h004;
  localparam logic [11:0] IEFC_PINEN_OFFS = 12'h008;
  localparam logic [11:0] IEFC_PSTAT_OFFS = 12'h00C;
  localparam logic [11:0] IEFC_EVST_OFFS = 12'h010;
  localparam logic [11:0] IEFC_EVMSK_OFFS = 12'h014;

  // Control register fields
  localparam int IEFC_GEN_BIT = 7;
  localparam int IEFC_PGE_BIT = 6;
  localparam int IEFC_T0E_BIT = 5;
  localparam int IEFC_EXE_BIT = 4;
  localparam int IEFC_PCE_BIT = 3;
  localparam int IEFC_T0F_BIT = 2;
  localparam int IEFC_EXF_BIT = 1;
  localparam int IEFC_PCF_BIT = 0;

  // Peripheral enable: implemented bits 6,5,4,3,1,0
  localparam logic [7:0] IEFC_PEN_MASK_FULL = 8'h7B;
  // Smaller variant lacks converter, capture/compare, timer two
  localparam logic [7:0] IEFC_PEN_MASK_SMALL = 8'h19;

  localparam logic [7:0] IEFC_CTRL_RST = 8'h00;
  localparam logic [7:0] IEFC_PEN_RST = 8'h00;
  localparam logic [5:0] IEFC_PINEN_RST = 6'h00;
  localparam logic [2:0] IEFC_EV_RST = 3'h0;

  localparam int IEFC_PORT_W = 6;

  typedef struct packed {
    logic timer_zero_roll;
    logic ext_pin_edge;
    logic port_changed;
  } iefc_event_type;

endpackage : iefc_pkg

// *** rtl/iefc_ctrl.sv ***
// Interrupt enable and flag registers with APB access and request output
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps

// Contract
// - Flags set on their condition regardless of own or global enable
// - Global enable bit 7 passes unmasked core requests, else blocks core_irq_req; event_irq ignores it
// - Peripheral group enable bit 6 gates every peripheral request
// - Timer-zero overflow flag bit 2 sticks until cleared; enable bit 5
// - Reset leaves timer-zero counter alone; software sets it first
// - External pin flag bit 1 sticks until cleared; enable bit 4
// - Port change flag bit 0 set on any change of a per-pin enabled pin among 5..0
// - Port change enable bit 3 works only for per-pin enabled pins
// - Control register fully read/write, resets to zero
// - Peripheral enable bit 5 gates capture/compare interrupt
// - Bits 4 and 3 gate comparator two and one interrupts
// - Bit 1 gates timer two match interrupt
// - Peripheral bits 7 and 2 read zero; implemented bits reset zero
module iefc_ctrl
  import iefc_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event sources (same clock domain)
  input wire logic timer_zero_rollover,
  input wire logic [5:0] general_io_port,
  input wire logic external_irq_pin,
  // Peripheral flags, level from their own flag bits
  input wire logic [7:0] peripheral_flags,
  // Request to core and block event interrupt
  output logic core_irq_req,
  output logic event_irq
);

  localparam logic [7:0] PEN_MASK =
    FULL_VARIANT ? IEFC_PEN_MASK_FULL : IEFC_PEN_MASK_SMALL;

  logic [7:0] ctrl_q;
  logic [7:0] pen_q;
  logic [5:0] pinen_q;
  logic [2:0] evst_q;
  logic [2:0] evmsk_q;
  logic [5:0] port_s1_q, port_s2_q, port_s3_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;

  // Pin inputs pass two flops; the third holds history for edge detection
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port_s1_q <= 6'h00;
      port_s2_q <= 6'h00;
      port_s3_q <= 6'h00;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      port_s1_q <= general_io_port;
      port_s2_q <= port_s1_q;
      port_s3_q <= port_s2_q;
      ext_s1_q <= external_irq_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // Only pins with their per-pin enable can raise a change event
  wire [5:0] pin_changed = (port_s2_q ^ port_s3_q) & pinen_q;
  wire ext_rise = ext_s2_q & ~ext_s3_q;

  iefc_event_type ev;
  assign ev.timer_zero_roll = timer_zero_rollover;
  assign ev.ext_pin_edge = ext_rise;
  assign ev.port_changed = |pin_changed;

  // APB decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  wire wr_en = psel & penable & pwrite;
  wire sel_ctrl = hit(paddr, IEFC_CTRL_OFFS);
  wire sel_pen = hit(paddr, IEFC_PEN_OFFS);
  wire sel_pinen = hit(paddr, IEFC_PINEN_OFFS);
  wire sel_pstat = hit(paddr, IEFC_PSTAT_OFFS);
  wire sel_evst = hit(paddr, IEFC_EVST_OFFS);
  wire sel_evmsk = hit(paddr, IEFC_EVMSK_OFFS);
  wire mapped = sel_ctrl | sel_pen | sel_pinen | sel_pstat | sel_evst |
                sel_evmsk;
  wire ctrl_wr = wr_en & sel_ctrl;

  // Flags: hardware set wins over a software write of zero
  wire [2:0] flag_set = {ev.timer_zero_roll, ev.ext_pin_edge,
                         ev.port_changed};
  wire [7:0] ctrl_base = ctrl_wr ? pwdata[7:0] : ctrl_q;
  wire [7:0] ctrl_d = {ctrl_base[7:3], ctrl_base[2:0] | flag_set};

  wire [7:0] pen_d = (wr_en & sel_pen) ? (pwdata[7:0] & PEN_MASK)
                                       : pen_q;
  wire [2:0] evst_d = (evst_q & ~((wr_en & sel_evst) ? pwdata[2:0] : 3'h0))
                      | flag_set;

  wire [5:0] pinen_d = (wr_en & sel_pinen) ? pwdata[5:0] : pinen_q;
  wire [2:0] evmsk_d = (wr_en & sel_evmsk) ? pwdata[2:0] : evmsk_q;

  // One short block per register keeps each reset value next to its use
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= IEFC_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pen_q <= IEFC_PEN_RST;
    end else begin
      pen_q <= pen_d;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pinen_q <= IEFC_PINEN_RST;
    end else begin
      pinen_q <= pinen_d;
    end
  end

  // Event status keeps set-wins ordering so no event is lost to a clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      evst_q <= IEFC_EV_RST;
    end else begin
      evst_q <= evst_d;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      evmsk_q <= IEFC_EV_RST;
    end else begin
      evmsk_q <= evmsk_d;
    end
  end

  // Request: core sources under global enable, peripherals also need group
  wire core_hit = (ctrl_q[IEFC_T0E_BIT] & ctrl_q[IEFC_T0F_BIT])
                | (ctrl_q[IEFC_EXE_BIT] & ctrl_q[IEFC_EXF_BIT])
                | (ctrl_q[IEFC_PCE_BIT] & ctrl_q[IEFC_PCF_BIT]);
  // Bits 6,5,4,3,1,0 gate converter, capture, comparators, timers
  wire [7:0] per_active = pen_q & peripheral_flags;
  wire per_hit = ctrl_q[IEFC_PGE_BIT] & (|per_active);
  assign core_irq_req = ctrl_q[IEFC_GEN_BIT] & (core_hit | per_hit);

  assign event_irq = |(evst_q & evmsk_q);

  // Read mux, unmapped addresses read zero and report an error
  wire [7:0] rd_byte = sel_ctrl ? ctrl_q :
                       sel_pen ? pen_q :
                       sel_pinen ? {2'b00, pinen_q} :
                       sel_pstat ? {2'b00, port_s2_q} :
                       sel_evst ? {5'h00, evst_q} :
                       sel_evmsk ? {5'h00, evmsk_q} : 8'h00;
  assign prdata = {24'h000000, rd_byte};
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // The timer-zero counter lives outside; reset here never touches it

  property flag_sets_p(ev_s, flg);
    @(posedge ref_clk) disable iff (!resetn) ev_s |=> flg;
  endproperty

  t0_flag_set_a: assert property (flag_sets_p(timer_zero_rollover,
    ctrl_q[IEFC_T0F_BIT])) else $error("timer-zero flag not set");
  ext_flag_set_a: assert property (flag_sets_p(ext_rise,
    ctrl_q[IEFC_EXF_BIT])) else $error("ext flag not set");
  port_flag_set_a: assert property (flag_sets_p(|pin_changed,
    ctrl_q[IEFC_PCF_BIT])) else $error("port flag not set");

  flag_indep_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (timer_zero_rollover && !ctrl_q[IEFC_GEN_BIT]) |=> ctrl_q[IEFC_T0F_BIT])
    else $error("flag depends on enable");

  flag_sticky_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ctrl_q[IEFC_EXF_BIT] && !ctrl_wr) |=> ctrl_q[IEFC_EXF_BIT])
    else $error("ext flag dropped");

  glb_block_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !ctrl_q[IEFC_GEN_BIT] |-> !core_irq_req)
    else $error("request while globally disabled");

  grp_block_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!ctrl_q[IEFC_PGE_BIT] && !core_hit) |-> !core_irq_req)
    else $error("peripheral request without group enable");

  req_t0_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ctrl_q[IEFC_GEN_BIT] && ctrl_q[IEFC_T0E_BIT] && ctrl_q[IEFC_T0F_BIT])
    |-> core_irq_req) else $error("missing timer-zero request");

  ctrl_rw_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ctrl_wr && flag_set == 3'h0) |=> ctrl_q == $past(pwdata[7:0]))
    else $error("control write lost");

  pen_unimpl_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (pen_q & ~PEN_MASK) == 8'h00)
    else $error("unimplemented enable bit set");

  per_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ctrl_q[7:6] == 2'b11 && |(pen_q & peripheral_flags)) |-> core_irq_req)
    else $error("peripheral request missing");

  // Named steps reused by the checks below
  sequence pen_write_s;
    wr_en && sel_pen;
  endsequence

  sequence pinen_write_s;
    wr_en && sel_pinen;
  endsequence

  sequence flag_event_s;
    flag_set != 3'h0;
  endsequence

  t0_sticky_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (ctrl_q[IEFC_T0F_BIT] && !ctrl_wr) |=> ctrl_q[IEFC_T0F_BIT])
    else $error("timer-zero flag dropped");

  port_sticky_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (ctrl_q[IEFC_PCF_BIT] && !ctrl_wr) |=> ctrl_q[IEFC_PCF_BIT])
    else $error("port flag dropped");

  ext_indep_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (ext_rise && !ctrl_q[IEFC_EXE_BIT]) |=> ctrl_q[IEFC_EXF_BIT])
    else $error("ext flag depends on enable");

  pen_write_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    pen_write_s |=> pen_q == ($past(pwdata[7:0]) & PEN_MASK))
    else $error("peripheral enable write wrong");

  req_ext_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (ctrl_q[IEFC_GEN_BIT] && ctrl_q[IEFC_EXE_BIT] && ctrl_q[IEFC_EXF_BIT])
    |-> core_irq_req) else $error("missing ext request");

  req_port_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (ctrl_q[IEFC_GEN_BIT] && ctrl_q[IEFC_PCE_BIT] && ctrl_q[IEFC_PCF_BIT])
    |-> core_irq_req) else $error("missing port request");

  core_mask_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (ctrl_q[7:3] == 5'b10000) |-> !core_irq_req)
    else $error("request with all sources disabled");

  per_mask_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (ctrl_q[7:6] == 2'b11 && !core_hit &&
     (pen_q & peripheral_flags) == 8'h00) |-> !core_irq_req)
    else $error("request from masked peripheral");

  pin_mask_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (pinen_q == 6'h00) |-> !ev.port_changed)
    else $error("change event from disabled pin");

  evst_set_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    flag_event_s |=> (evst_q & $past(flag_set)) == $past(flag_set))
    else $error("event status not set");

  unimpl_read_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (psel && sel_pen) |-> (prdata[7] == 1'b0 && prdata[2] == 1'b0))
    else $error("unimplemented bit reads one");

  ctrl_keep_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    ctrl_wr |=> ctrl_q[7:3] == $past(pwdata[7:3]))
    else $error("control enable write lost");

  pinen_keep_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    pinen_write_s |=> pinen_q == $past(pwdata[5:0]))
    else $error("per-pin enable write lost");

  t0_clear_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (ctrl_wr && !pwdata[IEFC_T0F_BIT] && !flag_set[2]) |=>
    !ctrl_q[IEFC_T0F_BIT]) else $error("timer-zero flag not cleared");

  ext_clear_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    (ctrl_wr && !pwdata[IEFC_EXF_BIT] && !flag_set[1]) |=>
    !ctrl_q[IEFC_EXF_BIT]) else $error("ext flag not cleared");

endmodule : iefc_ctrl

// *** bench/iefc_src_model.sv ***
// Event source model: timer zero, pins and peripheral flags
`timescale 1ns/100ps
module iefc_src_model (
  // Clock
  input wire logic ref_clk,
  // Event sources
  output logic timer_zero_rollover,
  output logic [5:0] general_io_port,
  output logic external_irq_pin,
  output logic [7:0] peripheral_flags
);
  // Not cleared by reset, as on the real timer
  logic [7:0] timer_zero_counter = 8'hFF;
  initial begin
    timer_zero_rollover = 1'b0;
    general_io_port = 6'h00;
    external_irq_pin = 1'b0;
    peripheral_flags = 8'h00;
  end
  // Pulse lasts one cycle, only on the FF to 00 wrap
  task automatic roll_over;
    @(posedge ref_clk);
    timer_zero_counter <= timer_zero_counter + 8'h01;
    timer_zero_rollover <= (timer_zero_counter == 8'hFF);
    @(posedge ref_clk);
    timer_zero_rollover <= 1'b0;
  endtask : roll_over
  task automatic set_in(input logic [5:0] p, input logic e,
                        input logic [7:0] f);
    @(posedge ref_clk);
    general_io_port <= p;
    external_irq_pin <= e;
    peripheral_flags <= f;
  endtask : set_in
endmodule : iefc_src_model

// *** bench/test_iefc_ctrl.sv ***
// Self-checking bench for the interrupt enable and flag controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  $display("BAD %s exp %h got %h", nm, e, g); error_cnt++; end end
module test_iefc_ctrl import iefc_pkg::*;;
  typedef struct {logic [31:0] d; logic err, ur, c, ev;} iefc_note_type;
  localparam logic [11:0] CT = IEFC_CTRL_OFFS;
  logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic core_irq_req, event_irq, tz_roll, ext_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [5:0] gpio;
  logic [7:0] pflags;
  iefc_note_type notes[$], nt;
  int error_cnt = 0, n_compared = 0;
  iefc_ctrl u_dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_zero_rollover(tz_roll), .general_io_port(gpio),
    .external_irq_pin(ext_pin), .peripheral_flags(pflags),
    .core_irq_req(core_irq_req), .event_irq(event_irq));
  iefc_src_model u_src (.ref_clk(ref_clk), .timer_zero_rollover(tz_roll),
    .general_io_port(gpio), .external_irq_pin(ext_pin),
    .peripheral_flags(pflags));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic finish_test;
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, {24'h0, d});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] x,
    input logic ur = 1'b0, input logic c = 1'b0, input logic e = 1'b0);
    notes.push_back('{{24'h0, x}, a > IEFC_EVMSK_OFFS, ur, c, e});
    apb(a, 1'b0, 32'h0);
  endtask : rd
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      nt = notes.pop_front();
      `CHK("prdata", nt.d, prdata)
      `CHK("pslverr", nt.err, pslverr)
      if (nt.ur) begin
        `CHK("core_irq_req", nt.c, core_irq_req)
        `CHK("event_irq", nt.ev, event_irq)
      end
    end
  end
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    v = $urandom(4896);
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(CT, 8'h00, 1'b1);
    rd(IEFC_PEN_OFFS, 8'h00);
    wr(CT, 8'hFF);
    rd(CT, 8'hFF, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      v = $urandom();
      wr(IEFC_PEN_OFFS, v[7:0]);
      rd(IEFC_PEN_OFFS, v[7:0] & IEFC_PEN_MASK_FULL);
    end
    rd(12'h018, 8'h00);
    wr(CT, 8'h00);
    u_src.roll_over();
    rd(CT, 8'h04, 1'b1);
    wr(IEFC_EVMSK_OFFS, 8'h04);
    rd(IEFC_EVST_OFFS, 8'h04, 1'b1, 1'b0, 1'b1);
    wr(IEFC_EVST_OFFS, 8'h04);
    rd(IEFC_EVST_OFFS, 8'h00, 1'b1);
    wr(CT, 8'hA4);
    rd(CT, 8'hA4, 1'b1, 1'b1);
    wr(CT, 8'h24);
    rd(CT, 8'h24, 1'b1);
    wr(CT, 8'h00);
    u_src.set_in(6'h00, 1'b1, 8'h00);
    repeat (4) @(posedge ref_clk);
    rd(CT, 8'h02, 1'b1);
    wr(CT, 8'h92);
    rd(CT, 8'h92, 1'b1, 1'b1);
    wr(IEFC_PINEN_OFFS, 8'h3F);
    wr(CT, 8'h00);
    u_src.set_in(6'h20, 1'b1, 8'h00);
    repeat (4) @(posedge ref_clk);
    rd(CT, 8'h01, 1'b1);
    rd(IEFC_PSTAT_OFFS, 8'h20);
    wr(CT, 8'h89);
    rd(CT, 8'h89, 1'b1, 1'b1);
    wr(IEFC_PINEN_OFFS, 8'h00);
    wr(CT, 8'h00);
    u_src.set_in(6'h00, 1'b1, 8'h00);
    repeat (4) @(posedge ref_clk);
    rd(CT, 8'h00, 1'b1);
    for (int i = 0; i < 8; i++) begin
      if (IEFC_PEN_MASK_FULL[i]) begin
        wr(IEFC_PEN_OFFS, 8'h01 << i);
        u_src.set_in(6'h00, 1'b1, 8'h01 << i);
        wr(CT, 8'hC0);
        rd(CT, 8'hC0, 1'b1, 1'b1);
        wr(CT, 8'h80);
        rd(CT, 8'h80, 1'b1);
      end
    end
    finish_test();
  end
endmodule : test_iefc_ctrl
